/* File: design/sfrpd_decoder.sv */
// Page-select register and page-aware address decoder for the register space.
// Summary of operation
// - Eight-bit read/write page select at 0xA7, every page, clears to zero.
// - Current page value picks the target of every register read and write outside 0xA7 and the common core registers.
// - 0xBA is accumulator config on page 0x0, burst power-up on page 0xF.
// - 0xA4 is port 0 output mode on page 0x0, drive strength on 0xF.
// - 0x97 is DC-DC control on page 0x0, CRC sector count on 0xF.
// - Common core registers such as 0xE6 answer identically on every page.
// - After reset all accesses go to page zero.
`timescale 1ns/1ps

module sfrpd_decoder (
	// Clock, reset and enable.
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// Direct-addressed accesses from the core.
	input wire logic [7:0] acc_addr_i,
	input wire logic acc_wr_i,
	input wire logic acc_rd_i,
	input wire logic [7:0] acc_wdata_i,
	output logic [7:0] acc_rdata_o,
	// Resolved access towards the register banks.
	output sfrpd_pkg::sfrpd_tgt_t per_sel_o,
	output logic per_wr_o,
	output logic per_rd_o,
	output logic [7:0] per_wdata_o,
	input wire logic [7:0] per_rdata_i,
	// Current page for observation.
	output logic [7:0] page_select_o
);

	// Maps a page and address to the register that answers there.
	function automatic sfrpd_pkg::sfrpd_tgt_t decode(input logic [7:0] page, input logic [7:0] addr);
		sfrpd_pkg::sfrpd_tgt_t t;
		t = sfrpd_pkg::TGT_NONE;
		if (addr < sfrpd_pkg::SFR_BASE)
			t = sfrpd_pkg::TGT_NONE;
		else if (addr == sfrpd_pkg::ADDR_PAGE_SELECT)
			t = sfrpd_pkg::TGT_PAGE_SELECT;
		else
		begin
			case (addr)
				8'h80, 8'h81, 8'h82, 8'h83, 8'h87, 8'h90, 8'hA0, 8'hA8, 8'hA9, 8'hD0, 8'hE0, 8'hE6, 8'hE7,
				8'hF0, 8'hF6, 8'hF7:
					// Common core registers answer the same whatever the page value is.
					t = sfrpd_pkg::TGT_COMMON;
				default:
					if (page == sfrpd_pkg::PAGE_ZERO)
					begin
						if (addr == sfrpd_pkg::ADDR_CONV_SHARED)
							t = sfrpd_pkg::TGT_CONV_ACCUM_CFG;
						else if (addr == sfrpd_pkg::ADDR_PORT0_SHARED)
							t = sfrpd_pkg::TGT_PORT0_OUT_MODE;
						else if (addr == sfrpd_pkg::ADDR_DCDC_SHARED)
							t = sfrpd_pkg::TGT_DCDC_CONTROL;
						else if (addr != sfrpd_pkg::ADDR_P0_HOLE_A && addr != sfrpd_pkg::ADDR_P0_HOLE_B &&
							addr != sfrpd_pkg::ADDR_P0_HOLE_C && addr != sfrpd_pkg::ADDR_P0_HOLE_D &&
							addr != sfrpd_pkg::ADDR_P0_HOLE_E)
							t = sfrpd_pkg::TGT_PAGE0_OTHER;
					end
					else if (page == sfrpd_pkg::PAGE_HIGH)
					begin
						if (addr == sfrpd_pkg::ADDR_CONV_SHARED)
							t = sfrpd_pkg::TGT_CONV_BURST_PWRUP;
						else if (addr == sfrpd_pkg::ADDR_PORT0_SHARED)
							t = sfrpd_pkg::TGT_PORT0_DRIVE;
						else if (addr == sfrpd_pkg::ADDR_DCDC_SHARED)
							t = sfrpd_pkg::TGT_CRC_SECTOR_COUNT;
						else
						begin
							case (addr)
								8'h85, 8'h86, 8'h91, 8'h92, 8'h93, 8'h95, 8'h96, 8'hA5, 8'hA6, 8'hBD:
									t = sfrpd_pkg::TGT_PAGEF_OTHER;
								default:
									t = sfrpd_pkg::TGT_NONE;
							endcase
						end
					end
			endcase
		end
		return t;
	endfunction

	logic [7:0] page_r;
	logic [7:0] page_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	sfrpd_pkg::sfrpd_tgt_t tgt;
	logic fwd;

	// Decode with the page value held before this cycle's write lands.
	assign tgt = decode(page_r, acc_addr_i);
	assign fwd = ce_i && tgt != sfrpd_pkg::TGT_NONE && tgt != sfrpd_pkg::TGT_PAGE_SELECT;

	// Forward accesses that resolve to a bank register; reserved ones go nowhere.
	assign per_sel_o = tgt;
	assign per_wr_o = fwd && acc_wr_i;
	assign per_rd_o = fwd && acc_rd_i;
	assign per_wdata_o = acc_wdata_i;
	assign page_select_o = page_r;
	assign acc_rdata_o = rdata_r;

	// Next page value and captured read data.
	always_comb
	begin
		page_nxt = page_r;
		rdata_nxt = rdata_r;
		if (ce_i && acc_wr_i && tgt == sfrpd_pkg::TGT_PAGE_SELECT)
			page_nxt = acc_wdata_i;
		if (ce_i && acc_rd_i)
		begin
			if (tgt == sfrpd_pkg::TGT_PAGE_SELECT)
				rdata_nxt = page_r;
			else if (tgt == sfrpd_pkg::TGT_NONE)
				rdata_nxt = 8'h00;
			else
				rdata_nxt = per_rdata_i;
		end
	end

	// Page register starts on page zero so reset leaves the default bank in view.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			page_r <= sfrpd_pkg::PAGE_RESET;
			rdata_r <= 8'h00;
		end
		else
		begin
			page_r <= page_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// A taken write of the page-select address.
	sequence s_page_write;
		ce_i && acc_wr_i && acc_addr_i == sfrpd_pkg::ADDR_PAGE_SELECT;
	endsequence

	// A taken write that moves the decoder to the high page.
	sequence s_go_high;
		ce_i && acc_wr_i && acc_addr_i == sfrpd_pkg::ADDR_PAGE_SELECT && acc_wdata_i == sfrpd_pkg::PAGE_HIGH;
	endsequence

	// A taken read that is forwarded to a bank register.
	sequence s_bank_read;
		ce_i && acc_rd_i && per_sel_o != sfrpd_pkg::TGT_NONE && per_sel_o != sfrpd_pkg::TGT_PAGE_SELECT;
	endsequence

	// Page-select register: write, read back, hold, freeze and reset value.
	a_page_write_lands: assert property (s_page_write |=> page_select_o == $past(acc_wdata_i))
		else $error("page select did not take the written value");
	a_page_read_back: assert property (ce_i && acc_rd_i && acc_addr_i == sfrpd_pkg::ADDR_PAGE_SELECT
		|=> acc_rdata_o == $past(page_select_o))
		else $error("page select read back wrong");
	a_page_holds: assert property (!(ce_i && acc_wr_i && acc_addr_i == sfrpd_pkg::ADDR_PAGE_SELECT)
		|=> $stable(page_select_o))
		else $error("page select changed without a write");
	a_page_no_strobe: assert property (per_sel_o == sfrpd_pkg::TGT_PAGE_SELECT |-> !per_wr_o && !per_rd_o)
		else $error("page select access reached the banks");
	a_freeze_hold: assert property (!ce_i |=> $stable(page_select_o) && $stable(acc_rdata_o))
		else $error("state moved while the clock enable was low");
	a_reset_page_zero: assert property ($rose(rst_n_i) |-> page_select_o == sfrpd_pkg::PAGE_ZERO)
		else $error("page not zero after reset");
	a_reset_rdata_zero: assert property ($rose(rst_n_i) |-> acc_rdata_o == 8'h00)
		else $error("read data not zero after reset");

	// Shared addresses resolve by page, and a page switch governs the next access.
	a_conv_split: assert property (acc_addr_i == sfrpd_pkg::ADDR_CONV_SHARED &&
		page_select_o == sfrpd_pkg::PAGE_HIGH |-> per_sel_o == sfrpd_pkg::TGT_CONV_BURST_PWRUP)
		else $error("0xBA on page 0xF misdecoded");
	a_conv_page_zero: assert property (acc_addr_i == sfrpd_pkg::ADDR_CONV_SHARED &&
		page_select_o == sfrpd_pkg::PAGE_ZERO |-> per_sel_o == sfrpd_pkg::TGT_CONV_ACCUM_CFG)
		else $error("0xBA on page 0x0 misdecoded");
	a_port0_split: assert property (acc_addr_i == sfrpd_pkg::ADDR_PORT0_SHARED &&
		page_select_o == sfrpd_pkg::PAGE_ZERO |-> per_sel_o == sfrpd_pkg::TGT_PORT0_OUT_MODE)
		else $error("0xA4 on page 0x0 misdecoded");
	a_port0_page_high: assert property (acc_addr_i == sfrpd_pkg::ADDR_PORT0_SHARED &&
		page_select_o == sfrpd_pkg::PAGE_HIGH |-> per_sel_o == sfrpd_pkg::TGT_PORT0_DRIVE)
		else $error("0xA4 on page 0xF misdecoded");
	a_dcdc_split: assert property (acc_addr_i == sfrpd_pkg::ADDR_DCDC_SHARED &&
		page_select_o == sfrpd_pkg::PAGE_HIGH |-> per_sel_o == sfrpd_pkg::TGT_CRC_SECTOR_COUNT)
		else $error("0x97 on page 0xF misdecoded");
	a_dcdc_page_zero: assert property (acc_addr_i == sfrpd_pkg::ADDR_DCDC_SHARED &&
		page_select_o == sfrpd_pkg::PAGE_ZERO |-> per_sel_o == sfrpd_pkg::TGT_DCDC_CONTROL)
		else $error("0x97 on page 0x0 misdecoded");
	a_page_applies_next: assert property (s_go_high ##1 acc_addr_i == sfrpd_pkg::ADDR_CONV_SHARED
		|-> per_sel_o == sfrpd_pkg::TGT_CONV_BURST_PWRUP)
		else $error("page switch did not govern the next access");
	a_common_any_page: assert property (acc_addr_i == sfrpd_pkg::ADDR_EXT_IRQ_ONE
		|-> per_sel_o == sfrpd_pkg::TGT_COMMON)
		else $error("common register not decoded on this page");

	// Forwarding to the banks, and silence of reserved locations.
	a_write_forward: assert property (ce_i && acc_wr_i && per_sel_o != sfrpd_pkg::TGT_NONE &&
		per_sel_o != sfrpd_pkg::TGT_PAGE_SELECT |-> per_wr_o && per_wdata_o == acc_wdata_i)
		else $error("bank write not forwarded");
	a_read_forward: assert property (s_bank_read |=> acc_rdata_o == $past(per_rdata_i))
		else $error("bank read data not captured");
	a_reserved_silent: assert property (ce_i && acc_rd_i && per_sel_o == sfrpd_pkg::TGT_NONE
		|-> !per_wr_o ##1 acc_rdata_o == 8'h00)
		else $error("reserved access not silent");
	a_reserved_no_strobe: assert property (per_sel_o == sfrpd_pkg::TGT_NONE |-> !per_wr_o && !per_rd_o)
		else $error("reserved access reached the banks");
	a_low_addr_reserved: assert property (acc_addr_i < sfrpd_pkg::SFR_BASE
		|-> per_sel_o == sfrpd_pkg::TGT_NONE)
		else $error("address below the register space decoded");
	a_hole_reserved: assert property (acc_addr_i == sfrpd_pkg::ADDR_P0_HOLE_A &&
		page_select_o == sfrpd_pkg::PAGE_ZERO |-> per_sel_o == sfrpd_pkg::TGT_NONE)
		else $error("empty page zero location decoded");
	a_hole_high_page: assert property (acc_addr_i == sfrpd_pkg::ADDR_P0_HOLE_B &&
		page_select_o == sfrpd_pkg::PAGE_HIGH |-> per_sel_o == sfrpd_pkg::TGT_NONE)
		else $error("empty high page location decoded");

endmodule

/* File: design/sfrpd_pkg.sv */
// Constants and types shared by the register page decoder.
package sfrpd_pkg;
	// Page values and reset value of the page-select register.
	localparam logic [7:0] PAGE_ZERO = 8'h00;
	localparam logic [7:0] PAGE_HIGH = 8'h0F;
	localparam logic [7:0] PAGE_RESET = 8'h00;
	// Lowest direct address of the register space.
	localparam logic [7:0] SFR_BASE = 8'h80;
	// Fixed addresses named by the decoder.
	localparam logic [7:0] ADDR_PAGE_SELECT = 8'hA7;
	localparam logic [7:0] ADDR_CONV_SHARED = 8'hBA;
	localparam logic [7:0] ADDR_PORT0_SHARED = 8'hA4;
	localparam logic [7:0] ADDR_DCDC_SHARED = 8'h97;
	localparam logic [7:0] ADDR_EXT_IRQ_ONE = 8'hE6;
	// Addresses that are empty on page zero.
	localparam logic [7:0] ADDR_P0_HOLE_A = 8'hAB;
	localparam logic [7:0] ADDR_P0_HOLE_B = 8'hAF;
	localparam logic [7:0] ADDR_P0_HOLE_C = 8'hB4;
	localparam logic [7:0] ADDR_P0_HOLE_D = 8'hB9;
	localparam logic [7:0] ADDR_P0_HOLE_E = 8'hE5;

	// Register targets that an access can resolve to.
	typedef enum logic [3:0] {
		TGT_NONE,
		TGT_PAGE_SELECT,
		TGT_COMMON,
		TGT_PAGE0_OTHER,
		TGT_PAGEF_OTHER,
		TGT_CONV_ACCUM_CFG,
		TGT_CONV_BURST_PWRUP,
		TGT_PORT0_OUT_MODE,
		TGT_PORT0_DRIVE,
		TGT_DCDC_CONTROL,
		TGT_CRC_SECTOR_COUNT
	} sfrpd_tgt_t;
endpackage

/* File: tb/sfrpd_bank_model.sv */
// Register bank model behind the page decoder.
`timescale 1ns/1ps
module sfrpd_bank_model (
	// Clock and bank port.
	input wire logic clk_i,
	input wire sfrpd_pkg::sfrpd_tgt_t sel_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [16];
	initial foreach (mem[i]) mem[i] = 8'h00;
	// Each target keeps its own byte, so a wrong page shows on readback.
	always @(posedge clk_i)
		if (wr_i) mem[sel_i] <= wdata_i;
	// Outside a read the bus toggles, so stale data never passes.
	assign rdata_o = rd_i ? mem[sel_i] : {8{clk_i}} ^ 8'hA5;
endmodule

/* File: tb/sfrpd_decoder_tb.sv */
// Self-checking bench for the page decoder.
`timescale 1ns/1ps
module sfrpd_decoder_tb;
	logic clk_i = 0, rst_n_i = 0, wr = 0, rd = 0, ce = 1, pw, pr, w;
	logic [7:0] addr = 8'h00, wd = 8'h00, rdata, page, brd, wdo, a, d, xpage = 8'h00, xrd = 8'h00;
	logic [7:0] mem [16];
	logic [16:0] seq [19] = '{17'h1BA11, 17'h1A422, 17'h19733, 17'h1E644, 17'h1AB55, 17'h1A70F,
		17'h0BA00, 17'h0A400, 17'h09700, 17'h0E600, 17'h1BA66, 17'h1A477, 17'h19788, 17'h1E699,
		17'h1A703, 17'h18012, 17'h0A700, 17'h1A700, 17'h0BA00};
	sfrpd_pkg::sfrpd_tgt_t sel;
	int error_cnt = 0, tests_run = 0;
	always #25 clk_i = ~clk_i;
	sfrpd_decoder uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .acc_addr_i(addr), .acc_wr_i(wr),
		.acc_rd_i(rd), .acc_wdata_i(wd), .acc_rdata_o(rdata), .per_sel_o(sel), .per_wr_o(pw),
		.per_rd_o(pr), .per_wdata_o(wdo), .per_rdata_i(brd), .page_select_o(page));
	sfrpd_bank_model bank (.clk_i(clk_i), .sel_i(sel), .wr_i(pw), .rd_i(pr), .wdata_i(wdo), .rdata_o(brd));
	// Expected target from page and address alone.
	function automatic sfrpd_pkg::sfrpd_tgt_t tgt(logic [7:0] p, logic [7:0] a);
		logic f;
		f = p == 8'h0F;
		if (a == 8'hA7) return sfrpd_pkg::TGT_PAGE_SELECT;
		if (a < 8'h80) return sfrpd_pkg::TGT_NONE;
		if (a inside {[8'h80:8'h83], 8'h87, 8'h90, 8'hA0, 8'hA8, 8'hA9, 8'hD0, 8'hE0, 8'hE6, 8'hE7,
			8'hF0, 8'hF6, 8'hF7}) return sfrpd_pkg::TGT_COMMON;
		if (p != 8'h00 && !f) return sfrpd_pkg::TGT_NONE;
		if (a == 8'hBA) return f ? sfrpd_pkg::TGT_CONV_BURST_PWRUP : sfrpd_pkg::TGT_CONV_ACCUM_CFG;
		if (a == 8'hA4) return f ? sfrpd_pkg::TGT_PORT0_DRIVE : sfrpd_pkg::TGT_PORT0_OUT_MODE;
		if (a == 8'h97) return f ? sfrpd_pkg::TGT_CRC_SECTOR_COUNT : sfrpd_pkg::TGT_DCDC_CONTROL;
		if (f) return a inside {8'h85, 8'h86, [8'h91:8'h96], 8'hA5, 8'hA6, 8'hBD} ?
			sfrpd_pkg::TGT_PAGEF_OTHER : sfrpd_pkg::TGT_NONE;
		return a inside {8'hAB, 8'hAF, 8'hB4, 8'hB9, 8'hE5} ? sfrpd_pkg::TGT_NONE : sfrpd_pkg::TGT_PAGE0_OTHER;
	endfunction
	// Byte comparison with counting.
	task automatic chk(string what, logic [7:0] e, logic [7:0] g);
		tests_run++;
		if (g !== e)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask
	// One access held for a cycle; strobes stay up for the next call to replace.
	task automatic acc(logic w, logic [7:0] a, logic [7:0] d, logic e = 1'b1);
		sfrpd_pkg::sfrpd_tgt_t t;
		logic m;
		t = tgt(xpage, a);
		m = e && t != sfrpd_pkg::TGT_NONE && t != sfrpd_pkg::TGT_PAGE_SELECT;
		addr = a;
		wd = d;
		wr = w;
		rd = !w;
		ce = e;
		#2;
		chk("target", {4'h0, t}, {4'h0, sel});
		chk("strobe", {6'h0, w & m, !w & m}, {6'h0, pw, pr});
		chk("wdata", d, wdo);
		@(posedge clk_i);
		#2;
		if (e && !w) xrd = t == sfrpd_pkg::TGT_PAGE_SELECT ? xpage : m ? mem[t] : 8'h00;
		else if (e && t == sfrpd_pkg::TGT_PAGE_SELECT) xpage = d;
		else if (m) mem[t] = d;
		if (!w) chk("rdata", xrd, rdata);
		chk("page", xpage, page);
	endtask
	// Verdict and end of run.
	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Reset, directed page cases, then random traffic.
	initial
	begin
		foreach (mem[i]) mem[i] = 8'h00;
		void'($urandom(75));
		repeat (2) @(posedge clk_i);
		#2;
		rst_n_i = 1;
		chk("page", 8'h00, page);
		chk("rdata", 8'h00, rdata);
		foreach (seq[i]) acc(seq[i][16], seq[i][15:8], seq[i][7:0]);
		acc(0, 8'h10, 0);
		acc(1, 8'hA7, 8'h0F);
		rst_n_i = 0;
		@(posedge clk_i);
		#2;
		chk("page", 8'h00, page);
		chk("rdata", 8'h00, rdata);
		rst_n_i = 1;
		xpage = 8'h00;
		xrd = 8'h00;
		$display("test directed done");
		repeat (400)
		begin
			w = 1'($urandom);
			a = $urandom % 6 == 0 ? 8'hA7 : 8'h80 | 8'($urandom);
			d = a == 8'hA7 && $urandom % 4 != 0 ? {4'h0, {4{1'($urandom)}}} : 8'($urandom);
			acc(w, a, d, $urandom % 8 != 0);
		end
		$display("test random done");
		test_done();
	end
endmodule
